// file: hw/cs_alu_pkg.sv
package cs_alu_pkg;

   // ==========================================
   // Instruction word layout
   localparam int OPCODE_MSB   = 31;
   localparam int OPCODE_LSB   = 20;
   localparam int OPERAND1_MSB = 19;
   localparam int OPERAND1_LSB = 10;
   localparam int OPERAND2_MSB = 9;
   localparam int OPERAND2_LSB = 0;

   // ==========================================
   // Opcode field layout
   localparam int PREFIX_MSB = 11;
   localparam int PREFIX_LSB = 10;
   localparam int CLASS_MSB  = 9;
   localparam int CLASS_LSB  = 7;
   localparam int SUBOP_MSB  = 6;
   localparam int SUBOP_LSB  = 0;

   // ==========================================
   // Opcode encodings
   localparam logic [11:0] OP_IDLE       = 12'h000;
   localparam logic [11:0] OP_LOAD       = 12'h080;
   localparam logic [11:0] OP_LOAD_INV   = 12'h480;
   localparam logic [11:0] OP_LOAD_ZERO  = 12'h081;
   localparam logic [11:0] OP_LOAD_ONES  = 12'h481;
   localparam logic [11:0] OP_ADD        = 12'h100;
   localparam logic [11:0] OP_SUB        = 12'h101;
   localparam logic [11:0] OP_AND        = 12'h102;
   localparam logic [11:0] OP_OR         = 12'h103;
   localparam logic [11:0] OP_XOR        = 12'h104;
   localparam logic [11:0] OP_STORE      = 12'h180;
   localparam logic [11:0] OP_STORE_INV  = 12'h580;

   // ==========================================
   // Operand selector encodings
   localparam logic [9:0] SEL_GPR_LAST  = 10'h00f;
   localparam logic [9:0] SEL_OPERAND_A = 10'h020;
   localparam logic [9:0] SEL_OPERAND_B = 10'h021;
   localparam logic [9:0] SEL_ACCUM     = 10'h031;
   localparam logic [9:0] SEL_ZERO      = 10'h032;
   localparam logic [9:0] SEL_CARRY     = 10'h033;

   // ==========================================
   // Sizes and reset values
   localparam int          DATA_WIDTH = 64;
   localparam int          GPR_COUNT  = 16;
   localparam logic [63:0] DATA_RESET = 64'h0000_0000_0000_0000;

   typedef enum logic [3:0] {
      KIND_IDLE      = 4'b0000,
      KIND_LOAD      = 4'b0001,
      KIND_LOAD_INV  = 4'b0010,
      KIND_LOAD_ZERO = 4'b0011,
      KIND_LOAD_ONES = 4'b0100,
      KIND_ADD       = 4'b0101,
      KIND_SUB       = 4'b0110,
      KIND_AND       = 4'b0111,
      KIND_OR        = 4'b1000,
      KIND_XOR       = 4'b1001,
      KIND_STORE     = 4'b1010,
      KIND_STORE_INV = 4'b1011,
      KIND_ILLEGAL   = 4'b1111
   } op_kind_t;

endpackage : cs_alu_pkg

// file: hw/cs_alu_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module cs_alu_decoder (
   input  wire logic [11:0]           opcode,
   output cs_alu_pkg::op_kind_t       kind
);

   // ==========================================
   // Opcode to operation kind
   // Prefix, class and sub-op fields combined
   always_comb begin
      case (opcode)
         cs_alu_pkg::OP_IDLE:      kind = cs_alu_pkg::KIND_IDLE;      // see (RL5)
         cs_alu_pkg::OP_LOAD:      kind = cs_alu_pkg::KIND_LOAD;      // see (RL3)
         cs_alu_pkg::OP_LOAD_INV:  kind = cs_alu_pkg::KIND_LOAD_INV;  // see (RL3)
         cs_alu_pkg::OP_LOAD_ZERO: kind = cs_alu_pkg::KIND_LOAD_ZERO; // see (RL3)
         cs_alu_pkg::OP_LOAD_ONES: kind = cs_alu_pkg::KIND_LOAD_ONES; // see (RL3)
         cs_alu_pkg::OP_ADD:       kind = cs_alu_pkg::KIND_ADD;       // see (RL4)
         cs_alu_pkg::OP_SUB:       kind = cs_alu_pkg::KIND_SUB;       // see (RL4)
         cs_alu_pkg::OP_AND:       kind = cs_alu_pkg::KIND_AND;       // see (RL4)
         cs_alu_pkg::OP_OR:        kind = cs_alu_pkg::KIND_OR;        // see (RL4)
         cs_alu_pkg::OP_XOR:       kind = cs_alu_pkg::KIND_XOR;       // see (RL4)
         cs_alu_pkg::OP_STORE:     kind = cs_alu_pkg::KIND_STORE;     // see (RL5)
         cs_alu_pkg::OP_STORE_INV: kind = cs_alu_pkg::KIND_STORE_INV; // see (RL5)
         default:                  kind = cs_alu_pkg::KIND_ILLEGAL;   // see (RL8)
      endcase
   end

endmodule : cs_alu_decoder
`default_nettype wire

// file: hw/command_stream_alu.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (RL1) Word: opcode bits 31:20, operand1 19:10, operand2 9:0.
// (RL2) Opcode: prefix 11:10, class 9:7, sub-operation 6:0.
// (RL3) Load family codes 0x080, 0x480, 0x081, 0x481.
// (RL4) Add 0x100, subtract 0x101, and 0x102, or 0x103, xor 0x104.
// (RL5) 0x000 idle changes nothing; 0x180 store, 0x580 inverted store.
// (RL6) Selectors 0x0..0xf address the sixteen general registers.
// (RL7) 0x20/0x21 operands A/B; 0x31/0x32/0x33 accumulator, zero, carry.
// (RL8) Only twelve opcodes are defined; others are flagged and ignored.
// (RL9) Issuer gives operand A/B then general register for loads.
// (RL10) Issuer gives general register then accumulator or flag for stores.
// (RL11) Inverted load complements; load-zero and load-ones write constants.
// (RL12) Arithmetic/logic ops combine A and B into accumulator and flags.
// (RL13) Storing a flag replicates it across all 64 bits.
// (RL14) Inverted store writes complement of accumulator or flag.
// (RL15) Zero when result is zero; carry out on add, borrow on subtract.
// (RL16) Instructions execute one at a time in issue order.
module command_stream_alu (
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        instr_valid,
   input  wire logic [31:0] instr_word,
   output logic             instr_ready,
   output logic             done,
   output logic             illegal_op,
   output logic             bad_operand,
   input  wire logic        gpr_write,
   input  wire logic [3:0]  gpr_index,
   input  wire logic [63:0] gpr_wdata,
   output logic [63:0]      gpr_rdata,
   output logic [63:0]      accumulator_reg,
   output logic             zero_flag,
   output logic             carry_flag
);

   // ==========================================
   // Storage
   logic [63:0]          streamer_general_registers [cs_alu_pkg::GPR_COUNT];
   logic [63:0]          operand_a_reg;
   logic [63:0]          operand_b_reg;
   cs_alu_pkg::op_kind_t kind;
   logic [11:0]          opcode;
   logic [9:0]           operand1;
   logic [9:0]           operand2;
   logic                 take;

   // Replicates one flag across a full word
   function automatic logic [63:0] spread(input logic bit_in);
      spread = {cs_alu_pkg::DATA_WIDTH{bit_in}};
   endfunction : spread

   // Selector addresses a general register
   function automatic logic is_gpr(input logic [9:0] sel);
      is_gpr = (sel <= cs_alu_pkg::SEL_GPR_LAST);
   endfunction : is_gpr

   // Selector names operand register A or B
   function automatic logic is_operand_reg(input logic [9:0] sel);
      is_operand_reg = (sel == cs_alu_pkg::SEL_OPERAND_A) ||
                       (sel == cs_alu_pkg::SEL_OPERAND_B);
   endfunction : is_operand_reg

   // ==========================================
   // Field split
   assign opcode   = instr_word[cs_alu_pkg::OPCODE_MSB:cs_alu_pkg::OPCODE_LSB];     // see (RL1)
   assign operand1 = instr_word[cs_alu_pkg::OPERAND1_MSB:cs_alu_pkg::OPERAND1_LSB]; // see (RL1)
   assign operand2 = instr_word[cs_alu_pkg::OPERAND2_MSB:cs_alu_pkg::OPERAND2_LSB]; // see (RL1)
   // Always ready: each word completes in its own cycle
   assign take     = instr_valid;                                                    // see (RL16)

   // Decoder matches prefix, class and sub-op together as one 12-bit opcode
   cs_alu_decoder u_decoder (
      .opcode (opcode),  // see (RL2)
      .kind   (kind)
   );

   // ==========================================
   // Operand source values
   logic [63:0] load_src;
   logic [63:0] store_src;
   logic        load_ok;
   logic        store_ok;

   // Load reads a general register, store reads accumulator or a flag
   always_comb begin
      load_src  = streamer_general_registers[operand2[3:0]];                // see (RL6)
      load_ok   = is_gpr(operand2) && is_operand_reg(operand1);            // see (RL9)
      store_ok  = is_gpr(operand1);                                          // see (RL10)
      case (operand2)
         cs_alu_pkg::SEL_ACCUM: store_src = accumulator_reg;                 // see (RL7)
         cs_alu_pkg::SEL_ZERO:  store_src = spread(zero_flag);               // see (RL13)
         cs_alu_pkg::SEL_CARRY: store_src = spread(carry_flag);              // see (RL13)
         default: begin
            store_src = cs_alu_pkg::DATA_RESET;
            store_ok  = 1'b0;
         end
      endcase
   end

   // ==========================================
   // Arithmetic and logic
   logic [64:0] result;
   logic [64:0] wide_a;
   logic [64:0] wide_b;

   // One spare bit catches carry out and borrow
   assign wide_a = {1'b0, operand_a_reg};
   assign wide_b = {1'b0, operand_b_reg};

   always_comb begin
      case (kind)
         cs_alu_pkg::KIND_ADD: result = wide_a + wide_b;                       // see (RL15)
         cs_alu_pkg::KIND_SUB: result = wide_a - wide_b;                       // see (RL15)
         cs_alu_pkg::KIND_AND: result = {1'b0, operand_a_reg & operand_b_reg};
         cs_alu_pkg::KIND_OR:  result = {1'b0, operand_a_reg | operand_b_reg};
         cs_alu_pkg::KIND_XOR: result = {1'b0, operand_a_reg ^ operand_b_reg};
         default:              result = {1'b0, accumulator_reg};
      endcase
   end

   logic is_arith;
   assign is_arith = (kind == cs_alu_pkg::KIND_ADD) || (kind == cs_alu_pkg::KIND_SUB) ||
                     (kind == cs_alu_pkg::KIND_AND) || (kind == cs_alu_pkg::KIND_OR) ||
                     (kind == cs_alu_pkg::KIND_XOR);

   // ==========================================
   // Operand registers
   logic [63:0] load_value;

   always_comb begin
      case (kind)
         cs_alu_pkg::KIND_LOAD_INV:  load_value = ~load_src;                  // see (RL11)
         cs_alu_pkg::KIND_LOAD_ZERO: load_value = spread(1'b0);               // see (RL11)
         cs_alu_pkg::KIND_LOAD_ONES: load_value = spread(1'b1);               // see (RL11)
         default:                    load_value = load_src;
      endcase
   end

   logic is_load;
   logic load_fixed;
   logic do_load;
   assign load_fixed = (kind == cs_alu_pkg::KIND_LOAD_ZERO) ||
                       (kind == cs_alu_pkg::KIND_LOAD_ONES);
   assign is_load    = (kind == cs_alu_pkg::KIND_LOAD) ||
                       (kind == cs_alu_pkg::KIND_LOAD_INV) || load_fixed;
   // Constant loads need only a valid target selector
   assign do_load    = take && is_load &&
                       (load_ok || (load_fixed && is_operand_reg(operand1)));

   // Loads are the only way to set operands A and B
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         operand_a_reg <= cs_alu_pkg::DATA_RESET;
         operand_b_reg <= cs_alu_pkg::DATA_RESET;
      end else if (do_load) begin
         if (operand1 == cs_alu_pkg::SEL_OPERAND_A) begin                      // see (RL7)
            operand_a_reg <= load_value;
         end else begin
            operand_b_reg <= load_value;
         end
      end
   end

   // ==========================================
   // Accumulator and flags
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         accumulator_reg <= cs_alu_pkg::DATA_RESET;
         zero_flag       <= 1'b0;
         carry_flag      <= 1'b0;
      end else if (take && is_arith) begin
         accumulator_reg <= result[63:0];                                     // see (RL12)
         zero_flag       <= (result[63:0] == cs_alu_pkg::DATA_RESET);         // see (RL15)
         carry_flag      <= result[64];                                       // see (RL15)
      end
   end

   // ==========================================
   // General registers: store path has priority over side write
   logic do_store;
   assign do_store = take && store_ok && ((kind == cs_alu_pkg::KIND_STORE) ||
                     (kind == cs_alu_pkg::KIND_STORE_INV));

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < cs_alu_pkg::GPR_COUNT; i++) begin
            streamer_general_registers[i] <= cs_alu_pkg::DATA_RESET;
         end
      end else if (do_store) begin
         if (kind == cs_alu_pkg::KIND_STORE_INV) begin
            streamer_general_registers[operand1[3:0]] <= ~store_src;           // see (RL14)
         end else begin
            streamer_general_registers[operand1[3:0]] <= store_src;            // see (RL13)
         end
      end else if (gpr_write) begin
         streamer_general_registers[gpr_index] <= gpr_wdata;
      end
   end

   // Read port for the streamer's register access path
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         gpr_rdata <= cs_alu_pkg::DATA_RESET;
      end else begin
         gpr_rdata <= streamer_general_registers[gpr_index];
      end
   end

   // ==========================================
   // Status pulses
   logic operand_bad;
   always_comb begin
      case (kind)
         cs_alu_pkg::KIND_LOAD, cs_alu_pkg::KIND_LOAD_INV: operand_bad = !load_ok;  // see (RL9)
         cs_alu_pkg::KIND_LOAD_ZERO, cs_alu_pkg::KIND_LOAD_ONES: operand_bad = !do_load;
         cs_alu_pkg::KIND_STORE, cs_alu_pkg::KIND_STORE_INV: operand_bad = !store_ok; // see (RL10)
         default: operand_bad = 1'b0;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         done        <= 1'b0;
         illegal_op  <= 1'b0;
         bad_operand <= 1'b0;
         instr_ready <= 1'b0;
      end else begin
         instr_ready <= 1'b1;
         done        <= take;
         illegal_op  <= take && (kind == cs_alu_pkg::KIND_ILLEGAL);           // see (RL8)
         bad_operand <= take && operand_bad;
      end
   end

endmodule : command_stream_alu
`default_nettype wire

// file: dv/cs_alu_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Instruction port checker
module cs_alu_monitor (
   input wire logic        clock,
   input wire logic        rst_b,
   input wire logic        instr_valid,
   input wire logic [31:0] instr_word,
   input wire logic        instr_ready,
   input wire logic        done,
   input wire logic        illegal_op,
   input wire logic        bad_operand,
   input wire logic [63:0] accumulator_reg,
   input wire logic        zero_flag,
   input wire logic        carry_flag
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // Opcode classification of the presented word
   logic [11:0] op;
   logic        legal;
   logic        arith;
   assign op    = instr_word[31:20];
   assign arith = op inside {[12'h100:12'h104]};
   assign legal = arith || op inside {12'h000, 12'h080, 12'h480, 12'h081,
                                      12'h481, 12'h180, 12'h580};
   ready_after_reset_a: assert property ($past(rst_b) |-> instr_ready)
      else $error("ready low after reset");
   done_pulse_a: assert property (instr_valid |=> done)
      else $error("no done after a taken word");
   quiet_idle_a: assert property (!instr_valid
      |=> !done && !illegal_op && !bad_operand)
      else $error("answer without a word");
   illegal_flag_a: assert property (instr_valid |=> illegal_op != $past(legal))
      else $error("illegal flag wrong");
   idle_clean_a: assert property (instr_valid && op == 12'h000
      |=> !illegal_op && !bad_operand)
      else $error("idle word flagged");
   accumulator_reg_hold_a: assert property (!(instr_valid && arith)
      |=> $stable(accumulator_reg) && $stable({zero_flag, carry_flag}))
      else $error("accumulator changed without an operation");
   zero_match_a: assert property (instr_valid && arith
      |=> zero_flag == (accumulator_reg == 64'h0))
      else $error("zero flag does not match result");
   logic_carry_a: assert property (instr_valid && op inside {[12'h102:12'h104]}
      |=> !carry_flag)
      else $error("carry set by logic op");
   bad_load_a: assert property (instr_valid && op inside {12'h080, 12'h480}
      && !(instr_word[19:10] inside {10'h020, 10'h021}) |=> bad_operand)
      else $error("bad load target not flagged");
endmodule : cs_alu_monitor
bind command_stream_alu cs_alu_monitor u_cs_alu_monitor (.clock, .rst_b, .instr_valid, .instr_word,
   .instr_ready, .done, .illegal_op, .bad_operand, .accumulator_reg, .zero_flag, .carry_flag);
`default_nettype wire

// file: dv/parser_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Command parser issuing instruction words
module parser_model (
   input  wire logic        clock,
   output logic             instr_valid,
   output logic [31:0]      instr_word,
   input  wire logic        done,
   input  wire logic        illegal_op,
   input  wire logic        bad_operand
);
   logic [2:0] seen; // Done, illegal, bad after the last word
   initial begin
      instr_valid = 1'b0;
      instr_word  = 32'h0000_0000;
      seen        = 3'h0;
   end
   // One word, then idle with a scrambled word, then capture the answer
   task automatic issue(input logic [31:0] w);
      @(posedge clock);
      instr_valid <= 1'b1;
      instr_word  <= w;
      @(posedge clock);
      instr_valid <= 1'b0;
      instr_word  <= ~w;
      #1 seen = {done, illegal_op, bad_operand};
   endtask : issue
   // Two words on consecutive edges
   task automatic issue2(input logic [31:0] w1, input logic [31:0] w2);
      @(posedge clock);
      instr_valid <= 1'b1;
      instr_word  <= w1;
      @(posedge clock);
      instr_word  <= w2;
      @(posedge clock);
      instr_valid <= 1'b0;
      instr_word  <= ~w2;
      #1 seen = {done, illegal_op, bad_operand};
   endtask : issue2
endmodule : parser_model
`default_nettype wire

// file: dv/command_stream_alu_bench.sv
`timescale 1ns/1ps
`default_nettype none
module command_stream_alu_bench;
   logic        clock, rst_b, instr_valid, instr_ready, done, illegal_op, bad_operand;
   logic        gpr_write, zero_flag, carry_flag;
   logic [3:0]  gpr_index;
   logic [31:0] instr_word;
   logic [63:0] gpr_wdata, gpr_rdata, accumulator_reg;
   int          fail_count, check_count;
   command_stream_alu u_command_stream_alu (.clock, .rst_b, .instr_valid, .instr_word,
      .instr_ready, .done, .illegal_op, .bad_operand, .gpr_write, .gpr_index, .gpr_wdata,
      .gpr_rdata, .accumulator_reg, .zero_flag, .carry_flag);
   parser_model u_parser_model (.clock, .instr_valid, .instr_word, .done, .illegal_op,
      .bad_operand);
   // ==========================================
   // Clock and helpers
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic state(input logic [63:0] e, input logic [1:0] zc);
      chk("accumulator", e, accumulator_reg);
      chk("zero carry", {62'h0, zc}, {62'h0, zero_flag, carry_flag});
   endtask : state
   task automatic ans(input logic [2:0] e);
      chk("answer", {61'h0, e}, {61'h0, u_parser_model.seen});
   endtask : ans
   task automatic run(input logic [11:0] op, input logic [9:0] o1, input logic [9:0] o2);
      u_parser_model.issue({op, o1, o2});
   endtask : run
   task automatic wr(input logic [3:0] i, input logic [63:0] d);
      @(posedge clock);
      gpr_write <= 1'b1;
      gpr_index <= i;
      gpr_wdata <= d;
      @(posedge clock);
      gpr_write <= 1'b0;
   endtask : wr
   task automatic rdchk(input logic [3:0] i, input logic [63:0] e);
      @(posedge clock);
      gpr_index <= i;
      @(posedge clock);
      #1 chk("general register", e, gpr_rdata);
   endtask : rdchk
   // ==========================================
   // Scenarios
   task automatic t_reset;
      state(64'h0, 2'b00);
      chk("ready", 64'h1, {63'h0, instr_ready});
      rdchk(4'hf, 64'h0);
      $display("test reset finished");
   endtask : t_reset
   task automatic t_arith;
      logic [63:0] a, b, e;
      logic        c;
      wr(4'h1, '1);
      wr(4'h2, 64'h1);
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 5; k++) begin
            a = p ? 64'h1 : '1;
            b = p ? '1 : 64'h1;
            run(12'h080, 10'h020, p ? 10'h002 : 10'h001);
            run(12'h080, 10'h021, p ? 10'h001 : 10'h002);
            run({9'h020, k[2:0]}, 10'h000, 10'h000);
            case (k)
               0: {c, e} = {1'b0, a} + {1'b0, b};
               1: begin
                  e = a - b;
                  c = a < b;
               end
               2: begin
                  e = a & b;
                  c = 1'b0;
               end
               3: begin
                  e = a | b;
                  c = 1'b0;
               end
               default: begin
                  e = a ^ b;
                  c = 1'b0;
               end
            endcase
            ans(3'b100);
            state(e, {e == 64'h0, c});
         end
      end
      $display("test arithmetic finished");
   endtask : t_arith
   task automatic t_move;
      wr(4'h3, 64'h0123_4567_89ab_cdef);
      run(12'h480, 10'h020, 10'h003);
      run(12'h081, 10'h021, 10'h000);
      run(12'h103, 10'h000, 10'h000);
      state(~64'h0123_4567_89ab_cdef, 2'b00);
      run(12'h481, 10'h021, 10'h000);
      run(12'h104, 10'h000, 10'h000);
      state(64'h0123_4567_89ab_cdef, 2'b00);
      run(12'h180, 10'h00f, 10'h031);
      run(12'h580, 10'h00e, 10'h031);
      run(12'h081, 10'h020, 10'h000);
      run(12'h102, 10'h000, 10'h000);
      state(64'h0, 2'b10);
      run(12'h180, 10'h00d, 10'h032);
      run(12'h580, 10'h00c, 10'h032);
      run(12'h580, 10'h000, 10'h033);
      rdchk(4'hf, 64'h0123_4567_89ab_cdef);
      rdchk(4'he, ~64'h0123_4567_89ab_cdef);
      rdchk(4'hd, '1);
      rdchk(4'hc, 64'h0);
      rdchk(4'h0, '1);
      $display("test load store finished");
   endtask : t_move
   task automatic t_order;
      wr(4'h4, 64'h5);
      wr(4'h5, 64'h3);
      u_parser_model.issue2({12'h080, 10'h020, 10'h004}, {12'h080, 10'h021, 10'h005});
      u_parser_model.issue2({12'h101, 20'h0}, {12'h180, 10'h001, 10'h031});
      state(64'h2, 2'b00);
      rdchk(4'h1, 64'h2);
      $display("test order finished");
   endtask : t_order
   task automatic t_refused;
      logic [11:0] bad [3] = '{12'h105, 12'h682, 12'hfff};
      foreach (bad[i]) begin
         run(bad[i], 10'h000, 10'h000);
         ans(3'b110);
         state(64'h2, 2'b00);
      end
      run(12'h000, 10'h000, 10'h000);
      ans(3'b100);
      state(64'h2, 2'b00);
      run(12'h080, 10'h000, 10'h005);
      ans(3'b101);
      run(12'h180, 10'h002, 10'h001);
      ans(3'b101);
      run(12'h100, 10'h000, 10'h000);
      state(64'h8, 2'b00);
      rdchk(4'h2, 64'h1);
      $display("test refused finished");
   endtask : t_refused
   // ==========================================
   // Verdict, watchdog and main sequence
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (5000) @(posedge clock);
      fail_count++;
      stop_test;
   end
   initial begin
      rst_b = 1'b0;
      gpr_write = 1'b0;
      gpr_index = 4'h0;
      gpr_wdata = 64'h0;
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      #1 t_reset;
      t_arith;
      t_move;
      t_order;
      t_refused;
      stop_test;
   end
endmodule : command_stream_alu_bench
`default_nettype wire
